// >>> inc/fpc_pkg.sv
package fpc_pkg;
  // Core clock and the switching timebase.
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 40;
  localparam int SW_HZ = 50_000;
  localparam int BASE_CYC = CLK_HZ / SW_HZ;
  localparam int DITHER_PCT = 4;
  localparam int DITHER_CYC = BASE_CYC * DITHER_PCT / 100;
  localparam int BLANK_NS = 250;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int DUTY_MAX_PCT = 80;
  localparam int MAX_ON_CYC = BASE_CYC * DUTY_MAX_PCT / 100;
  localparam int SS_MS = 4;
  localparam int SS_CYC = CLK_HZ / 1000 * SS_MS;
  localparam int DB_MS = 42;
  localparam int DB_CYC = CLK_HZ / 1000 * DB_MS;

  // Oscillator period per feedback band.
  localparam int OSC_W = 12;
  localparam int DITHER_W = 6;
  localparam int BLANK_W = 3;
  localparam int LIM_W = 8;
  localparam logic [OSC_W-1:0] PER_FULL = OSC_W'(BASE_CYC);
  localparam logic [OSC_W-1:0] PER_75 = OSC_W'(BASE_CYC * 4 / 3);
  localparam logic [OSC_W-1:0] PER_50 = OSC_W'(BASE_CYC * 2);
  localparam logic [OSC_W-1:0] PER_25 = OSC_W'(BASE_CYC * 4);
  localparam logic [OSC_W-1:0] MAX_ON = OSC_W'(MAX_ON_CYC);
  localparam logic [DITHER_W-1:0] DITHER_MID = DITHER_W'(DITHER_CYC);
  localparam logic [DITHER_W-1:0] DITHER_SPAN = DITHER_W'(2 * DITHER_CYC);
  localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_CYC);
  localparam logic [1:0] BAND_FULL = 2'h3;
  localparam logic [1:0] BAND_75 = 2'h2;
  localparam logic [1:0] BAND_50 = 2'h1;

  // Register map.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h10;
  localparam int CTRL_DITHER_BIT = 0;
  localparam int CTRL_FREQRED_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_GATE_BIT = 2;
  localparam int ST_SKIP_BIT = 3;
  localparam int ST_LIM_LSB = 8;
  localparam int IRQ_W = 4;
  localparam int IRQ_PROT_BIT = 0;
  localparam int IRQ_SKIP_BIT = 1;
  localparam int IRQ_LOCK_BIT = 2;
  localparam int IRQ_SSDONE_BIT = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;

  typedef enum logic [1:0] {
    FPC_ST_OFF,
    FPC_ST_SOFT,
    FPC_ST_RUN,
    FPC_ST_PROT
  } fpc_state_t;
endpackage

// >>> logic/fpc_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Gate stays off until the supply turn-on comparator fires.
// - Supply turn-off clears any protection and returns to the off state.
// - Soft start ramps the current-limit code from zero to full.
// - Every restart, retries included, runs the whole soft-start ramp.
// - Normal switching runs at a fixed nominal period from the core clock.
// - The period dithers symmetrically within plus or minus four percent.
// - A compensation ramp synchronous to each cycle feeds current sensing.
// - The current comparators cannot end a pulse during turn-on blanking.
// - Light load lowers switching frequency by feedback band.
// - Feedback below skip threshold suppresses all gate pulses.
// - Switching resumes once feedback rises above skip threshold.
// - A triggered protection stops switching until supply turn-off.
// - After restart a lasting fault trips again, else switching continues.
// - Supply overvoltage trips the same auto-recovery protection.
// - Slow faults trip only after persisting longer than the debounce time.
// - Floating pin or shorted timing resistor pin trips at once.
module fpc_core #(
  parameter int SS_CYCLES = fpc_pkg::SS_CYC,
  parameter int DB_CYCLES = fpc_pkg::DB_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_supply_on,
  input wire logic i_supply_off,
  input wire logic [1:0] i_feedback_level,
  input wire logic i_fb_skip,
  input wire logic i_cs_trip,
  input wire logic i_ilimit_trip,
  input wire logic i_overload_fault,
  input wire logic i_overcurrent_fault,
  input wire logic i_overpower_fault,
  input wire logic i_open_loop_fault,
  input wire logic i_supply_overvoltage_fault,
  input wire logic i_pin_floating,
  input wire logic i_timing_resistor_pin_short,
  input wire logic [fpc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [fpc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [fpc_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq,
  output logic o_gate,
  output logic [fpc_pkg::LIM_W-1:0] o_ilimit_code,
  output logic [7:0] o_slope_ramp
);
  import fpc_pkg::*;

  localparam int SS_STEP = SS_CYCLES / 256;
  localparam int SS_CW = $clog2(SS_STEP + 1);
  localparam int DB_CW = $clog2(DB_CYCLES + 1);
  localparam logic [SS_CW-1:0] SS_LAST = SS_CW'(SS_STEP - 1);
  localparam logic [DB_CW-1:0] DB_LAST = DB_CW'(DB_CYCLES);

  generate
    if (SS_CYCLES < 256 || DB_CYCLES < 1)
    begin : g_bad_param
      $error("fpc_core: soft start or debounce count too small");
    end
  endgenerate

  fpc_state_t state_ff, nxt_state;
  logic [OSC_W-1:0] osc_cnt_ff, nxt_osc_cnt;
  logic [DITHER_W-1:0] dither_ff, nxt_dither;
  logic dither_up_ff, nxt_dither_up;
  logic gate_ff, nxt_gate;
  logic [BLANK_W-1:0] blank_ff, nxt_blank;
  logic [SS_CW-1:0] ss_step_ff, nxt_ss_step;
  logic [LIM_W-1:0] ss_code_ff, nxt_ss_code;
  logic [DB_CW-1:0] db_cnt_ff, nxt_db_cnt;
  logic skip_ff;
  logic [7:0] slope_ff, nxt_slope;
  logic [1:0] ctrl_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff, nxt_irq_stat;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;

  wire switching = (state_ff == FPC_ST_SOFT) || (state_ff == FPC_ST_RUN);
  wire [1:0] band = ctrl_ff[CTRL_FREQRED_BIT] ? i_feedback_level : BAND_FULL;
  wire [DITHER_W-1:0] dith = ctrl_ff[CTRL_DITHER_BIT] ? dither_ff
                                                      : DITHER_MID;
  // Reduced frequency per feedback band.
  // band period select
  wire [OSC_W-1:0] base_per = (band == BAND_FULL) ? PER_FULL :
                              (band == BAND_75) ? PER_75 :
                              (band == BAND_50) ? PER_50 : PER_25;
  wire [OSC_W-1:0] period = base_per + OSC_W'(dith) - OSC_W'(DITHER_MID);
  wire osc_wrap = (osc_cnt_ff == period - OSC_W'(1));

  wire slow_fault = i_overload_fault || i_overcurrent_fault
                    || i_overpower_fault || i_open_loop_fault;
  wire db_trip = slow_fault && (db_cnt_ff == DB_LAST);
  wire fast_fault = i_supply_overvoltage_fault || i_pin_floating
                    || i_timing_resistor_pin_short;
  wire trip_now = switching && (fast_fault || db_trip);
  wire ss_done = (state_ff == FPC_ST_SOFT) && (ss_code_ff == 8'hff)
                 && (ss_step_ff == SS_LAST);

  wire end_pulse = ((blank_ff == '0) && (i_cs_trip || i_ilimit_trip))
                   || (osc_cnt_ff >= MAX_ON - OSC_W'(1));
  wire kill = !switching || i_fb_skip || trip_now || i_supply_off;

  assign nxt_gate = kill ? 1'b0 :
                    osc_wrap ? 1'b1 :
                    (gate_ff && end_pulse) ? 1'b0 : gate_ff;
  assign nxt_blank = (!kill && osc_wrap) ? BLANK_LOAD :
                     (blank_ff != '0) ? blank_ff - BLANK_W'(1) : blank_ff;
  assign nxt_osc_cnt = (!switching || osc_wrap) ? '0
                                                : osc_cnt_ff + OSC_W'(1);
  assign nxt_dither_up = (dither_ff == DITHER_SPAN) ? 1'b0 :
                         (dither_ff == '0) ? 1'b1 : dither_up_ff;
  assign nxt_dither = !osc_wrap ? dither_ff :
                      nxt_dither_up ? dither_ff + DITHER_W'(1)
                                    : dither_ff - DITHER_W'(1);
  assign nxt_slope = nxt_gate ? nxt_osc_cnt[8:1] : 8'h00;

  assign nxt_ss_step = (state_ff != FPC_ST_SOFT || ss_step_ff == SS_LAST)
                       ? '0 : ss_step_ff + SS_CW'(1);
  assign nxt_ss_code = (state_ff == FPC_ST_RUN) ? 8'hff :
                       (state_ff != FPC_ST_SOFT) ? 8'h00 :
                       (ss_step_ff == SS_LAST && ss_code_ff != 8'hff)
                       ? ss_code_ff + 8'h01 : ss_code_ff;
  assign nxt_db_cnt = (!switching || !slow_fault) ? '0 :
                      (db_cnt_ff != DB_LAST) ? db_cnt_ff + DB_CW'(1)
                                             : db_cnt_ff;

  always_comb
  begin
    nxt_state = state_ff;
    if (i_supply_off)
    begin
      nxt_state = FPC_ST_OFF;
    end
    else
    begin
      case (state_ff)
        FPC_ST_OFF:
          if (i_supply_on) nxt_state = FPC_ST_SOFT;
        FPC_ST_SOFT:
          if (trip_now) nxt_state = FPC_ST_PROT;
          else if (ss_done) nxt_state = FPC_ST_RUN;
        FPC_ST_RUN:
          if (trip_now) nxt_state = FPC_ST_PROT;
        default:
          nxt_state = FPC_ST_PROT;
      endcase
    end
  end

  // Sticky interrupt causes; a new event beats a clear in the same cycle.
  wire [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_PROT_BIT] = trip_now && !i_supply_off;
  assign irq_ev[IRQ_SKIP_BIT] = switching && i_fb_skip && !skip_ff;
  assign irq_ev[IRQ_LOCK_BIT] = i_supply_off && (state_ff != FPC_ST_OFF);
  assign irq_ev[IRQ_SSDONE_BIT] = ss_done && !trip_now && !i_supply_off;
  wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
  wire wr_en = i_wr && (i_addr == REG_IRQ_EN);
  wire wr_clr = i_wr && (i_addr == REG_IRQ_CLR);
  assign nxt_irq_stat = irq_ev
                        | (irq_stat_ff & ~(wr_clr ? i_wdata[IRQ_W-1:0] : '0));

  // Read mux; unmapped and write-only addresses read zero.
  wire [DATA_W-1:0] state_word = (DATA_W'(ss_code_ff) << ST_LIM_LSB)
                                 | (DATA_W'(skip_ff) << ST_SKIP_BIT)
                                 | (DATA_W'(gate_ff) << ST_GATE_BIT)
                                 | (DATA_W'(state_ff) << ST_STATE_LSB);
  always_comb
  begin
    nxt_rdata = '0;
    if (!i_rd)
      nxt_rdata = '0;
    else if (i_addr == REG_CTRL)
      nxt_rdata = DATA_W'(ctrl_ff);
    else if (i_addr == REG_STATE)
      nxt_rdata = state_word;
    else if (i_addr == REG_IRQ_STAT)
      nxt_rdata = DATA_W'(irq_stat_ff);
    else if (i_addr == REG_IRQ_EN)
      nxt_rdata = DATA_W'(irq_en_ff);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state_ff <= FPC_ST_OFF;
      osc_cnt_ff <= '0;
      dither_ff <= DITHER_MID;
      dither_up_ff <= 1'b1;
      gate_ff <= 1'b0;
      blank_ff <= '0;
      slope_ff <= 8'h00;
    end
    else if (i_ce)
    begin
      state_ff <= nxt_state;
      osc_cnt_ff <= nxt_osc_cnt;
      dither_ff <= nxt_dither;
      dither_up_ff <= nxt_dither_up;
      gate_ff <= nxt_gate;
      blank_ff <= nxt_blank;
      slope_ff <= nxt_slope;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      ss_step_ff <= '0;
      ss_code_ff <= 8'h00;
      db_cnt_ff <= '0;
      skip_ff <= 1'b0;
      ctrl_ff <= CTRL_RESET;
      irq_stat_ff <= '0;
      irq_en_ff <= IRQ_EN_RESET;
      rdata_ff <= '0;
    end
    else if (i_ce)
    begin
      ss_step_ff <= nxt_ss_step;
      ss_code_ff <= nxt_ss_code;
      db_cnt_ff <= nxt_db_cnt;
      skip_ff <= i_fb_skip;
      ctrl_ff <= wr_ctrl ? i_wdata[1:0] : ctrl_ff;
      irq_stat_ff <= nxt_irq_stat;
      irq_en_ff <= wr_en ? i_wdata[IRQ_W-1:0] : irq_en_ff;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_gate = gate_ff;
  assign o_ilimit_code = ss_code_ff;
  assign o_slope_ramp = slope_ff;
  assign o_rdata = rdata_ff;
  assign o_irq = |(irq_stat_ff & irq_en_ff);

  // Gate is never on outside soft start and run.
  property p_gate_off_idle;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (state_ff == FPC_ST_OFF || state_ff == FPC_ST_PROT) |-> !o_gate;
  endproperty
  a_gate_off_idle: assert property (p_gate_off_idle)
    else $error("gate active while not switching");

  property p_lockout_reset;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && i_supply_off) |=> (state_ff == FPC_ST_OFF && !o_gate);
  endproperty
  a_lockout_reset: assert property (p_lockout_reset)
    else $error("supply turn-off did not return to off state");

  property p_ss_monotonic;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (state_ff == FPC_ST_SOFT && i_ce && !i_supply_off)
      |=> (o_ilimit_code >= $past(o_ilimit_code));
  endproperty
  a_ss_monotonic: assert property (p_ss_monotonic)
    else $error("soft-start limit decreased");

  property p_restart_soft;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (state_ff == FPC_ST_OFF && i_ce && i_supply_on && !i_supply_off)
      |=> (state_ff == FPC_ST_SOFT && o_ilimit_code == 8'h00);
  endproperty
  a_restart_soft: assert property (p_restart_soft)
    else $error("restart did not begin a fresh soft start");

  property p_dither_band;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (band == BAND_FULL) |-> (period >= PER_FULL - OSC_W'(DITHER_CYC)
                             && period <= PER_FULL + OSC_W'(DITHER_CYC));
  endproperty
  a_dither_band: assert property (p_dither_band)
    else $error("switching period outside dither band");

  property p_blanking;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (o_gate && blank_ff != '0 && i_ce && !kill) |=> o_gate;
  endproperty
  a_blanking: assert property (p_blanking)
    else $error("pulse ended during turn-on blanking");

  property p_skip;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && i_fb_skip) |=> !o_gate;
  endproperty
  a_skip: assert property (p_skip)
    else $error("gate pulse while in skip");

  property p_prot_latched;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (state_ff == FPC_ST_PROT && !i_supply_off) |=> (state_ff == FPC_ST_PROT);
  endproperty
  a_prot_latched: assert property (p_prot_latched)
    else $error("protection left without supply turn-off");

  property p_fast_trip;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && switching && !i_supply_off && i_pin_floating)
      |=> (state_ff == FPC_ST_PROT && !o_gate);
  endproperty
  a_fast_trip: assert property (p_fast_trip)
    else $error("floating pin did not trip at once");

  property p_db_clear;
    @(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && !slow_fault) |=> (db_cnt_ff == '0);
  endproperty
  a_db_clear: assert property (p_db_clear)
    else $error("debounce timer kept counting without fault");

  property p_pulse_start;
    @(posedge i_core_clk) disable iff (!i_nrst)
    $rose(o_gate) |-> ($past(osc_wrap) && osc_cnt_ff == '0);
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("gate pulse began away from cycle start");
endmodule // fpc_core

// >>> test/fpc_core_tb.sv
`timescale 1ns/1ps
module fpc_core_tb;
  import fpc_pkg::*;
  localparam int SS = 512;
  localparam int DB = 20;
  logic clk, nrst, sup_on, sup_off, skip, wr, rd, irq, gate, cs_t, il_t;
  logic [1:0] fb;
  logic [6:0] flt;
  logic [7:0] addr, il_code, slope;
  logic [31:0] wdata, rdata;
  logic [11:0] trip_cyc;
  logic [31:0] exp_q[$], msk_q[$];
  logic gate_q, rd_seen;
  int err_total, checks_done, per_cnt, last_per, on_cnt, last_on, rises;
  int pk, last_pk, r0, lo, hi, t;

  fpc_core #(.SS_CYCLES(SS), .DB_CYCLES(DB)) uut (.i_core_clk(clk),
    .i_nrst(nrst), .i_ce(1'b1), .i_supply_on(sup_on), .i_supply_off(sup_off),
    .i_feedback_level(fb), .i_fb_skip(skip), .i_cs_trip(cs_t),
    .i_ilimit_trip(il_t), .i_overload_fault(flt[0]),
    .i_overcurrent_fault(flt[1]), .i_overpower_fault(flt[2]),
    .i_open_loop_fault(flt[3]), .i_supply_overvoltage_fault(flt[4]),
    .i_pin_floating(flt[5]), .i_timing_resistor_pin_short(flt[6]),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_irq(irq), .o_gate(gate), .o_ilimit_code(il_code),
    .o_slope_ramp(slope));
  fpc_stage_model stage (.i_core_clk(clk), .i_gate(gate),
    .i_ilimit_code(il_code), .i_trip_cyc(trip_cyc), .o_cs_trip(cs_t),
    .o_ilimit_trip(il_t));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] ex,
                         input string what);
    checks_done++;
    if (got !== ex)
    begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, ex);
    end
  endtask

  task automatic chk_rd(input logic [31:0] got);
    logic [31:0] e, m;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    checks_done++;
    if ((got & m) !== (e & m))
    begin
      err_total++;
      $display("[ERR] %0t read data %h exp %h", $time, got, e);
    end
  endtask

  // Read data lands in the cycle after the strobe; pulses are timed here.
  always @(posedge clk)
  begin
    if (rd_seen === 1'b1)
      chk_rd(rdata);
    rd_seen = rd & nrst;
    per_cnt++;
    if (gate === 1'b1 && gate_q !== 1'b1)
    begin
      last_per = per_cnt;
      per_cnt = 0;
      on_cnt = 0;
      pk = 0;
      rises++;
    end
    if (gate === 1'b1)
    begin
      on_cnt++;
      if (slope > pk)
        pk = slope;
    end
    if (gate !== 1'b1 && gate_q === 1'b1)
    begin
      last_on = on_cnt;
      last_pk = pk;
    end
    gate_q = gate;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic supply(input logic on);
    @(posedge clk);
    sup_on <= on;
    sup_off <= !on;
    @(posedge clk);
    sup_on <= 1'b0;
    sup_off <= 1'b0;
  endtask

  task automatic wait_rise(input int lim);
    int r;
    r = rises;
    repeat (lim) if (rises == r) @(posedge clk);
    chk_val(32'(rises != r), 32'h1, "no gate pulse");
  endtask

  task automatic period_is(input logic [11:0] p);
    repeat (3) wait_rise(2200);
    chk_val(32'(last_per), 32'(p), "period");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #(40 * 90000);
    err_total++;
    finish_test();
  end

  initial
  begin
    {nrst, sup_on, sup_off, skip, wr, rd, rd_seen, gate_q} = 8'h00;
    {fb, flt, addr, wdata, trip_cyc} = {2'h3, 7'h00, 8'h00, 32'h0, 12'hfff};
    {err_total, checks_done, per_cnt, rises, pk, last_pk} = 0;
    void'($urandom(32'h361b0f54));
    cyc(3);
    nrst <= 1'b1;
    rd_reg(REG_CTRL, 32'h3, 32'h3);
    rd_reg(REG_IRQ_EN, 32'h0, 32'hf);
    rd_reg(8'h20, 32'h0, 32'hffffffff);
    rd_reg(REG_STATE, 32'h0, 32'h7);
    cyc(600);
    chk_val(32'(rises), 32'h0, "gate before turn-on");
    supply(1'b1);
    cyc(4);
    chk_val(32'(il_code < 8'h10), 32'h1, "limit start");
    rd_reg(REG_STATE, 32'h1, 32'h3);
    cyc(250);
    chk_val(32'(il_code > 8'h10 && il_code < 8'hf0), 32'h1, "ramp");
    cyc(300);
    chk_val(32'(il_code), 32'hff, "limit end");
    rd_reg(REG_STATE, 32'h2, 32'h3);
    chk_val(32'(irq), 32'h0, "masked irq");
    wr_reg(REG_IRQ_EN, 32'h8);
    cyc(2);
    chk_val(32'(irq), 32'h1, "irq raised");
    wr_reg(REG_IRQ_CLR, 32'hf);
    cyc(2);
    chk_val(32'(irq), 32'h0, "irq cleared");
    wr_reg(REG_CTRL, 32'h2);
    period_is(PER_FULL);
    trip_cyc <= 12'h000;
    period_is(PER_FULL);
    r0 = (last_on >= BLANK_CYC && last_on <= BLANK_CYC + 2);
    chk_val(32'(r0), 1, "blank");
    t = 100 + $urandom % 100;
    trip_cyc <= 12'(t);
    period_is(PER_FULL);
    chk_val(32'(last_on >= t && last_on <= t + 3), 32'h1, "width");
    chk_val(32'(last_pk >= t / 4 && last_pk <= t / 2 + 2), 1, "s");
    trip_cyc <= 12'hfff;
    period_is(PER_FULL);
    r0 = (last_on >= MAX_ON_CYC - 2 && last_on <= MAX_ON_CYC);
    chk_val(32'(r0), 1, "max on");
    for (int b = 2; b >= 0; b--)
    begin
      fb <= 2'(b);
      period_is(b == 2 ? PER_75 : (b == 1 ? PER_50 : PER_25));
    end
    fb <= 2'h3;
    wr_reg(REG_CTRL, 32'h3);
    repeat (3) wait_rise(2200);
    lo = 9999;
    hi = 0;
    repeat (45)
    begin
      wait_rise(600);
      lo = (last_per < lo) ? last_per : lo;
      hi = (last_per > hi) ? last_per : hi;
    end
    r0 = (lo >= BASE_CYC - DITHER_CYC && lo < BASE_CYC);
    chk_val(32'(r0), 1, "lo");
    r0 = (hi <= BASE_CYC + DITHER_CYC && hi > BASE_CYC);
    chk_val(32'(r0), 1, "hi");
    skip <= 1'b1;
    cyc(3);
    r0 = rises;
    cyc(2500);
    chk_val(32'(rises == r0 && gate === 1'b0), 32'h1, "skip");
    chk_val(32'(slope), 32'h0, "idle ramp");
    rd_reg(REG_IRQ_STAT, 32'h2, 32'h2);
    skip <= 1'b0;
    wait_rise(600);
    for (int i = 0; i < 7; i++)
    begin
      if (i < 4)
      begin
        repeat (2)
        begin
          flt[i] <= 1'b1;
          cyc(DB);
          flt[i] <= 1'b0;
          cyc(1);
        end
        rd_reg(REG_STATE, 32'h2, 32'h3);
      end
      flt[i] <= 1'b1;
      cyc(i < 4 ? DB + 3 : 2);
      rd_reg(REG_STATE, 32'h3, 32'h3);
      r0 = rises;
      cyc(800);
      chk_val(32'(rises == r0 && gate === 1'b0), 32'h1, "held");
      supply(1'b0);
      rd_reg(REG_STATE, 32'h0, 32'h3);
      rd_reg(REG_IRQ_STAT, 32'h5, 32'h5);
      wr_reg(REG_IRQ_CLR, 32'hf);
      supply(1'b1);
      cyc(3);
      chk_val(32'(il_code < 8'h10), 32'h1, "restart ramp");
      cyc(DB + 3);
      rd_reg(REG_STATE, 32'h3, 32'h3);
      flt[i] <= 1'b0;
      supply(1'b0);
      supply(1'b1);
      cyc(SS + 20);
      rd_reg(REG_STATE, 32'h2, 32'h3);
    end
    cyc(5);
    finish_test();
  end
endmodule // fpc_core_tb

// >>> test/fpc_stage_model.sv
`timescale 1ns/1ps
module fpc_stage_model (
  input wire logic i_core_clk,
  input wire logic i_gate,
  input wire logic [7:0] i_ilimit_code,
  input wire logic [11:0] i_trip_cyc,
  output logic o_cs_trip,
  output logic o_ilimit_trip
);
  logic [11:0] ramp_ff;

  // Primary current builds while the switch conducts and collapses after.
  always_ff @(posedge i_core_clk)
  begin
    if (i_gate)
      ramp_ff <= ramp_ff + 12'h001;
    else
      ramp_ff <= 12'h000;
  end

  // The loop comparator trips at a chosen on-time, the limit one at twice the code.
  assign o_cs_trip = i_gate && (ramp_ff >= i_trip_cyc);
  assign o_ilimit_trip = i_gate && (ramp_ff[11:1] >= {3'h0, i_ilimit_code});
endmodule // fpc_stage_model
